// ### cssc_pkg.sv
// Shared constants for the charger two-wire status/control link.
// Assumes both ends are clocked by one 250 MHz clock and see the same bus.
package cssc_pkg;
  // ****************************************************************
  // Bus address and register map
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h6b;
  localparam logic [7:0] REG_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam int KICK_BIT = 7;
  localparam int STATE_MSB = 6;
  localparam int STATE_LSB = 4;
  localparam int PRIO_BIT = 3;
  localparam int FAULT_MSB = 2;
  localparam int FAULT_LSB = 0;
  localparam logic PRIO_RESET = 1'b0;
  // ****************************************************************
  // Charge-state codes
  // ****************************************************************
  localparam logic [2:0] ST_NO_SOURCE = 3'h0;
  localparam logic [2:0] ST_ADAPTER_READY = 3'h1;
  localparam logic [2:0] ST_USB_READY = 3'h2;
  localparam logic [2:0] ST_CHG_ADAPTER = 3'h3;
  localparam logic [2:0] ST_CHG_USB = 3'h4;
  localparam logic [2:0] ST_DONE = 3'h5;
  localparam logic [2:0] ST_FAULT = 3'h7;
  localparam logic [2:0] FLT_NONE = 3'h0;
  // ****************************************************************
  // Timing: host bus clock half period and startup step
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int BUS_KBPS = 400;
  localparam int HALF_CYC = (CLK_MHZ * 1000) / (BUS_KBPS * 2);
  // Each bus bit is four host phases: set data, raise, sample, lower
  localparam int QUARTER_CYC = HALF_CYC / 2;
  localparam int SOFT_START_NS = 1000;
  localparam int SOFT_START_CYC = (SOFT_START_NS * CLK_MHZ) / 1000;
  localparam int SRC_DETECT_NS = 1000;
  localparam int SRC_DETECT_CYC = (SRC_DETECT_NS * CLK_MHZ) / 1000;
  // Avalon register offsets of the host controller (word index)
  localparam logic [1:0] HOST_CMD = 2'h0;
  localparam logic [1:0] HOST_STATUS = 2'h1;
  localparam logic [1:0] HOST_RDATA = 2'h2;
endpackage : cssc_pkg

// ### cssc_bus_if.sv
// Two-wire bus between the charger slave and its host master.
// Assumes open-drain wires with pull-ups: a line is low if anyone drives it.
`timescale 1ns/1ps
interface cssc_bus_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // Wired-AND resolution; drivers only ever pull low
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport device (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_o_host, output scl_oe_host, output sda_oe_host);
endinterface : cssc_bus_if

// ### cssc_device.sv
// Overview of operation
// - Default mode, good battery forces high impedance
// - Host mode ignores good-battery comparison
// - Slave only; standard and fast rates
// - Seven-bit addressing, fixed address only
// - Start is SDA falling while SCL high
// - SDA changes only while SCL low
// - Acknowledge address match through ninth high
// - Receiver acknowledges each byte
// - Stop releases bus, await start+address
// - Master sends stop after aborted transfer
// - Unmapped register reads return all ones
// - Register zero resets bits 7,3 clear
// - Kick bit restarts watchdog, reads zero
// - Bits 6:4 report charge state
// - Bits 2:0 report fault code
// - Priority bit: zero adapter, one USB
// - Only one input charges at once
// - Priority change: high-Z, switch, full startup
// - Preferred arriving while charging other: same restart
// - Primary states move autonomously on conditions
// - Charging sub-states chosen from measurements
// - Faults latch, first kept, clear on read
//
// Device end: two-wire slave plus status/control register and a compact
// charger state model. Assumes analog conditions arrive as plain inputs.
`timescale 1ns/1ps
module cssc_device (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Two-wire bus
  cssc_bus_if.device bus,
  // Analog condition inputs
  input wire logic adapter_ok_i,
  input wire logic usb_ok_i,
  input wire logic battery_above_good_i,
  input wire logic host_mode_i,
  input wire logic charge_disable_pin_i,
  input wire logic charge_full_i,
  input wire logic battery_low_i,
  input wire logic current_reduce_i,
  input wire logic [2:0] fault_cond_i,
  // Status outputs
  output logic charge_adapter_o,
  output logic charge_usb_o,
  output logic high_z_o,
  output logic watchdog_restart_o,
  output logic [1:0] sub_state_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [4:0] {
    B_IDLE = 5'h01, B_SHIFT = 5'h02, B_ACK = 5'h04, B_SEND = 5'h08, B_MACK = 5'h10
  } cssc_bus_st_t;
  typedef enum logic [3:0] {
    C_HIZ = 4'h1, C_DETECT = 4'h2, C_SOFT = 4'h4, C_CHARGE = 4'h8
  } cssc_chg_st_t;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_lv;
    logic sda_lv;
    cssc_bus_st_t bst;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [1:0] byten;
    logic rd;
    logic [7:0] ptr;
    logic sda_oe;
    logic prio;
    logic [2:0] fault;
    cssc_chg_st_t cst;
    logic [15:0] tmr;
    logic use_usb;
    logic kick;
    logic [1:0] sub;
  } cssc_dev_t;
  cssc_dev_t r;
  cssc_dev_t next_r;
  logic scl_v;
  logic sda_v;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic both;
  logic want_usb;
  logic [7:0] reg_rd;
  // Synchronised levels: stages 2 and 3 must agree before a change counts
  function automatic logic settled(input logic [2:0] s, input logic prev);
    settled = (s[1] == s[2]) ? s[1] : prev;
  endfunction : settled
  always_comb
  begin
    // Accepted levels move only when stages 2 and 3 agree on a new value
    scl_v = r.scl_lv;
    sda_v = r.sda_lv;
    scl_rise = !scl_v && settled(r.scl_s, scl_v);
    scl_fall = scl_v && !settled(r.scl_s, scl_v);
    start_c = scl_v && !scl_fall && sda_v && !settled(r.sda_s, sda_v);
    stop_c = scl_v && !scl_fall && !sda_v && settled(r.sda_s, sda_v);
  end
  // ****************************************************************
  // Live status
  // ****************************************************************
  always_comb
  begin
    both = adapter_ok_i && usb_ok_i;
    want_usb = both ? r.prio : usb_ok_i;
    reg_rd = 8'h00;
    if (r.fault != cssc_pkg::FLT_NONE)
      reg_rd[cssc_pkg::STATE_MSB:cssc_pkg::STATE_LSB] = cssc_pkg::ST_FAULT;
    else if (r.cst == C_CHARGE && charge_full_i)
      reg_rd[cssc_pkg::STATE_MSB:cssc_pkg::STATE_LSB] = cssc_pkg::ST_DONE;
    else if (r.cst == C_CHARGE)
      reg_rd[cssc_pkg::STATE_MSB:cssc_pkg::STATE_LSB] =
        r.use_usb ? cssc_pkg::ST_CHG_USB : cssc_pkg::ST_CHG_ADAPTER;
    else if (adapter_ok_i || usb_ok_i)
      reg_rd[cssc_pkg::STATE_MSB:cssc_pkg::STATE_LSB] =
        want_usb ? cssc_pkg::ST_USB_READY : cssc_pkg::ST_ADAPTER_READY;
    else
      reg_rd[cssc_pkg::STATE_MSB:cssc_pkg::STATE_LSB] = cssc_pkg::ST_NO_SOURCE;
    reg_rd[cssc_pkg::PRIO_BIT] = r.prio;
    reg_rd[cssc_pkg::FAULT_MSB:cssc_pkg::FAULT_LSB] = r.fault;
    reg_rd[cssc_pkg::KICK_BIT] = 1'b0;
    if (r.ptr != cssc_pkg::REG_STATUS_CONTROL)
      reg_rd = cssc_pkg::UNMAPPED_READ;
  end
  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    next_r.kick = 1'b0;
    next_r.scl_s = {r.scl_s[1:0], bus.scl};
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    next_r.scl_lv = settled(r.scl_s, scl_v);
    next_r.sda_lv = settled(r.sda_s, sda_v);
    // Bus engine: start and stop count only when SCL is not falling in the same cycle
    if (start_c)
    begin
      next_r.bst = B_SHIFT;
      next_r.bitn = 4'h0;
      next_r.byten = 2'h0;
      next_r.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_r.bst = B_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      // Sample on the rising edge; the sender only moved SDA while SCL was low
      case (r.bst)
        B_SHIFT:
        begin
          next_r.shreg = {r.shreg[6:0], sda_v};
          next_r.bitn = r.bitn + 4'h1;
        end
        B_MACK:
          if (sda_v)
            next_r.bst = B_IDLE; // Master NACK ends the read
        default:
          next_r.bst = r.bst;
      endcase
    end
    else if (scl_fall)
    begin
      // Falling edge of SCL: drive or release SDA for the next bit
      case (r.bst)
        B_SHIFT:
          if (r.bitn == 4'h8)
          begin
            next_r.bitn = 4'h0;
            if (r.byten == 2'h0)
            begin
              if (r.shreg[7:1] == cssc_pkg::SLAVE_ADDR)
              begin
                next_r.rd = r.shreg[0];
                next_r.sda_oe = 1'b1;
                next_r.bst = B_ACK;
              end
              else
                next_r.bst = B_IDLE;
            end
            else
            begin
              next_r.sda_oe = 1'b1;
              next_r.bst = B_ACK;
              if (r.byten == 2'h1)
                next_r.ptr = r.shreg;
              else if (r.ptr == cssc_pkg::REG_STATUS_CONTROL)
              begin
                next_r.prio = r.shreg[cssc_pkg::PRIO_BIT];
                next_r.kick = r.shreg[cssc_pkg::KICK_BIT];
              end
            end
            if (r.byten != 2'h2)
              next_r.byten = r.byten + 2'h1;
          end
        B_ACK, B_MACK:
        begin
          if (r.rd)
          begin
            next_r.shreg = {reg_rd[6:0], 1'b0};
            next_r.sda_oe = !reg_rd[7];
            next_r.bitn = 4'h1;
            next_r.bst = B_SEND;
            if (r.ptr == cssc_pkg::REG_STATUS_CONTROL && fault_cond_i == cssc_pkg::FLT_NONE)
              next_r.fault = cssc_pkg::FLT_NONE;
          end
          else
          begin
            next_r.sda_oe = 1'b0;
            next_r.bst = B_SHIFT;
          end
        end
        B_SEND:
          if (r.bitn == 4'h8)
          begin
            next_r.sda_oe = 1'b0;
            next_r.bst = B_MACK;
          end
          else
          begin
            next_r.sda_oe = !r.shreg[7];
            next_r.shreg = {r.shreg[6:0], 1'b0};
            next_r.bitn = r.bitn + 4'h1;
          end
        default:
          next_r.bst = r.bst;
      endcase
    end
    // Fault latch: first fault stays until read with the condition gone
    if (r.fault == cssc_pkg::FLT_NONE && fault_cond_i != cssc_pkg::FLT_NONE)
      next_r.fault = fault_cond_i;
    // Charger model: high-Z, detect, soft-start, charge
    if (r.tmr != 16'h0000)
      next_r.tmr = r.tmr - 16'h0001;
    case (r.cst)
      C_HIZ:
        if ((adapter_ok_i || usb_ok_i) && !(battery_above_good_i && !host_mode_i))
        begin
          next_r.use_usb = want_usb;
          next_r.tmr = 16'(cssc_pkg::SRC_DETECT_CYC);
          next_r.cst = C_DETECT;
        end
      C_DETECT:
        if (r.tmr == 16'h0000)
        begin
          next_r.tmr = 16'(cssc_pkg::SOFT_START_CYC);
          next_r.cst = C_SOFT;
        end
      C_SOFT:
        if (r.tmr == 16'h0000)
          next_r.cst = C_CHARGE;
      default:
        next_r.cst = r.cst;
    endcase
    // Loss of the used input, fault, disable, priority change or preferred arrival restarts
    if (r.cst != C_HIZ && ((want_usb != r.use_usb) || !(adapter_ok_i || usb_ok_i)
        || charge_disable_pin_i || r.fault != cssc_pkg::FLT_NONE
        || (battery_above_good_i && !host_mode_i)))
      next_r.cst = C_HIZ;
    // Sub-state: 0 conditioning, 1 CC, 2 reduced CC, 3 reduced CV
    if (battery_low_i)
      next_r.sub = 2'h0;
    else if (current_reduce_i)
      next_r.sub = charge_full_i ? 2'h3 : 2'h2;
    else
      next_r.sub = 2'h1;
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.scl_lv <= 1'b1;
      r.sda_lv <= 1'b1;
      r.bst <= B_IDLE;
      r.cst <= C_HIZ;
      r.prio <= cssc_pkg::PRIO_RESET;
    end
    else
      r <= next_r;
  end
  // Outputs straight from flip-flops, except the two charge outputs decoded from cst and use_usb
  assign bus.sda_oe_dev = r.sda_oe;
  assign charge_adapter_o = (r.cst == C_CHARGE) && !r.use_usb;
  assign charge_usb_o = (r.cst == C_CHARGE) && r.use_usb;
  assign high_z_o = r.cst[0];
  assign watchdog_restart_o = r.kick;
  assign sub_state_o = r.sub;
endmodule : cssc_device

// ### cssc_host.sv
// Host end: two-wire master driven from Avalon-MM registers.
// Assumes one clock; the bus clock is made by a divider and driven out.
`timescale 1ns/1ps
module cssc_host (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Two-wire bus
  cssc_bus_if.host bus
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BITS = 4'h4, H_STOP = 4'h8
  } cssc_host_st_t;
  typedef struct packed {
    cssc_host_st_t st;
    logic [15:0] div;
    logic [1:0] ph;
    logic [5:0] bitn;
    logic [26:0] tx;
    logic [7:0] rx;
    logic nack;
    logic rdop;
    logic sda_oe;
    logic scl_oe;
    logic [31:0] rdata;
    logic wait_n;
  } cssc_host_s_t;
  cssc_host_s_t r;
  cssc_host_s_t next_r;
  logic tick;
  // Command word: bit 8 read, bits 7:0 pointer and bits 15:8 data (write only; a read uses the stored pointer)
  always_comb
  begin
    next_r = r;
    tick = (r.div == 16'(cssc_pkg::QUARTER_CYC - 1));
    next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
    next_r.wait_n = 1'b0;
    if ((avs_read_i || avs_write_i) && !r.wait_n)
    begin
      next_r.wait_n = 1'b1;
      if (avs_read_i)
        next_r.rdata = (avs_address_i == cssc_pkg::HOST_STATUS) ? {31'h0, r.st != H_IDLE}
          : (avs_address_i == cssc_pkg::HOST_RDATA) ? {23'h0, r.nack, r.rx} : 32'h0;
      else if (avs_address_i == cssc_pkg::HOST_CMD && r.st == H_IDLE)
      begin
        // Write: addr+W, pointer, data. Read: addr+R then one byte, NACKed.
        next_r.tx = avs_writedata_i[8]
          ? {cssc_pkg::SLAVE_ADDR, 1'b1, 1'b1, 8'hff, 1'b1, 9'h1ff}
          : {cssc_pkg::SLAVE_ADDR, 1'b0, 1'b1, avs_writedata_i[7:0], 1'b1,
             avs_writedata_i[15:8], 1'b1};
        next_r.bitn = avs_writedata_i[8] ? 6'd18 : 6'd27;
        next_r.nack = 1'b0;
        next_r.rdop = avs_writedata_i[8];
        next_r.st = H_START;
        next_r.ph = 2'h0;
      end
    end
    if (tick)
    begin
      // Phase stays zero while idle so a new command always opens with a start
      if (r.st != H_IDLE)
        next_r.ph = r.ph + 2'h1;
      case (r.st)
        H_START:
          if (r.ph == 2'h0)
            next_r.sda_oe = 1'b1; // SDA falls while SCL high
          else
          begin
            next_r.scl_oe = 1'b1;
            next_r.ph = 2'h0;
            next_r.st = H_BITS;
          end
        H_BITS:
          case (r.ph)
            2'h0: next_r.sda_oe = !r.tx[26]; // Change only with SCL low
            2'h1: next_r.scl_oe = 1'b0;
            2'h2:
            begin
              // The last slot of a read is our own NACK, not the slave's answer
              if (r.bitn == 6'd19 || r.bitn == 6'd10 || (r.bitn == 6'd1 && !r.rdop))
                next_r.nack = r.nack | bus.sda;
              if (r.bitn <= 6'd9 && r.bitn >= 6'd2)
                next_r.rx = {r.rx[6:0], bus.sda};
            end
            default:
            begin
              next_r.scl_oe = 1'b1;
              next_r.tx = {r.tx[25:0], 1'b1};
              next_r.bitn = r.bitn - 6'd1;
              next_r.ph = 2'h0;
              if (r.bitn == 6'd1)
                next_r.st = H_STOP;
            end
          endcase
        H_STOP:
          case (r.ph)
            2'h0: next_r.sda_oe = 1'b1;
            2'h1: next_r.scl_oe = 1'b0;
            2'h2: next_r.sda_oe = 1'b0; // SDA rises while SCL high
            default: next_r.st = H_IDLE;
          endcase
        default:
          next_r.ph = 2'h0;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.st <= H_IDLE;
    end
    else
      r <= next_r;
  end
  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = !r.wait_n;
  assign bus.scl_o_host = 1'b0;
  assign bus.scl_oe_host = r.scl_oe;
  assign bus.sda_oe_host = r.sda_oe;
endmodule : cssc_host

// ### cssc_checker.sv
// Bus-level checker for the two-wire link between host and charger.
// Assumes it sees the resolved wires and every pull-low enable.
`timescale 1ns/1ps
module cssc_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Bus wires and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_dev,
  input wire logic sda_oe_host,
  input wire logic scl_oe_host,
  input wire logic scl_o_host
);
  // ****************************************************************
  // Bus event tracking
  // ****************************************************************
  logic scl_q;
  logic sda_q;
  logic act;
  logic rw;
  logic [5:0] cnt;
  logic [7:0] sh;
  logic [7:0] ptr;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  wire ack_slot = rise && ((cnt % 6'd9) == 6'd8);

  // Bit count restarts at each start; the pointer is byte two of a write
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      act <= 1'b0;
      rw <= 1'b0;
      cnt <= 6'h00;
      sh <= 8'h00;
      ptr <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        act <= 1'b1;
        cnt <= 6'h00;
      end
      else if (stop)
        act <= 1'b0;
      else if (rise)
      begin
        cnt <= cnt + 6'h01;
        sh <= {sh[6:0], sda};
        if (cnt == 6'd7)
          rw <= sda;
        if (cnt == 6'd16 && !rw)
          ptr <= {sh[6:0], sda};
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence ack_edge;
    rise && cnt == 6'd8;
  endsequence
  sequence addr_ok;
    sh[7:1] == cssc_pkg::SLAVE_ADDR;
  endsequence
  sequence stop_seen;
    stop;
  endsequence

  dev_sda_stable_a: assert property (scl && scl_q |-> $stable(sda_oe_dev))
    else $error("device moved data while clock high");
  addr_quiet_a: assert property (act && !start && cnt < 6'd8 |-> !sda_oe_dev)
    else $error("device drove during address byte");
  addr_ack_a: assert property (ack_edge ##0 addr_ok |-> sda_oe_dev && !sda)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (rise && cnt == 6'd8 && sh[7:1] != cssc_pkg::SLAVE_ADDR
    |-> !sda_oe_dev)
    else $error("foreign address acknowledged");
  wr_ack_a: assert property (ack_slot && cnt != 6'd8 && !rw |-> sda_oe_dev)
    else $error("written byte not acknowledged");
  rd_release_a: assert property (ack_slot && cnt != 6'd8 && rw |-> !sda_oe_dev)
    else $error("device held line in master ack slot");
  unmapped_ones_a: assert property (rise && rw && cnt > 6'd8 && cnt < 6'd17
    && ptr != cssc_pkg::REG_STATUS_CONTROL |-> !sda_oe_dev)
    else $error("unmapped read not all ones");
  kick_zero_a: assert property (rise && rw && cnt == 6'd9
    && ptr == cssc_pkg::REG_STATUS_CONTROL |-> sda_oe_dev)
    else $error("kick bit read as one");
  stop_release_a: assert property (stop_seen |=> !sda_oe_dev [*8])
    else $error("device drove after stop");
endmodule : cssc_checker

// ### charger_serial_status_control_bench.sv
// Bench joining host and charger ends over the two-wire bus.
// Assumes a 250 MHz clock; one bus transfer takes about 12000 (read) to 18000 (write) cycles.
`timescale 1ns/1ps
module charger_serial_status_control_bench;
  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] avs_address_i = 2'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic adapter_ok_i = 1'b1;
  logic usb_ok_i = 1'b1;
  logic battery_above_good_i = 1'b1;
  logic host_mode_i = 1'b0;
  logic charge_adapter_o;
  logic charge_usb_o;
  logic high_z_o;
  logic watchdog_restart_o;
  logic hz_q = 1'b0;
  logic [31:0] rd;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int kicks = 0;
  int hz_rises = 0;
  int hz_before;
  int kick_before;
  cssc_bus_if bus ();

  always #2 ref_clk_i = ~ref_clk_i;

  cssc_host i_cssc_host (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .bus(bus)
  );
  // Fault and charge-phase inputs held quiet; bus time limits the run
  cssc_device i_cssc_device (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .bus(bus),
    .adapter_ok_i(adapter_ok_i),
    .usb_ok_i(usb_ok_i),
    .battery_above_good_i(battery_above_good_i),
    .host_mode_i(host_mode_i),
    .charge_disable_pin_i(1'b0),
    .charge_full_i(1'b0),
    .battery_low_i(1'b0),
    .current_reduce_i(1'b0),
    .fault_cond_i(3'h0),
    .charge_adapter_o(charge_adapter_o),
    .charge_usb_o(charge_usb_o),
    .high_z_o(high_z_o),
    .watchdog_restart_o(watchdog_restart_o),
    .sub_state_o()
  );
  cssc_checker i_cssc_checker (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .scl(bus.scl),
    .sda(bus.sda),
    .sda_oe_dev(bus.sda_oe_dev),
    .sda_oe_host(bus.sda_oe_host),
    .scl_oe_host(bus.scl_oe_host),
    .scl_o_host(bus.scl_o_host)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus_op(input logic [1:0] a, input logic wr, input logic [31:0] wd);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do
      @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus_op

  // One bus transfer: command, poll until idle, then masked result compare
  task automatic xfer(input logic [31:0] cmd, input logic [8:0] mask, input logic [8:0] exp);
    int n;
    n = 0;
    bus_op(cssc_pkg::HOST_CMD, 1'b1, cmd);
    do
    begin
      bus_op(cssc_pkg::HOST_STATUS, 1'b0, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 30000);
    bus_op(cssc_pkg::HOST_RDATA, 1'b0, 32'h0);
    check({23'h0, rd[8:0] & mask}, {23'h0, exp});
  endtask : xfer

  // Pulse counters, supply overlap watch and the hang limit
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    hz_q <= high_z_o;
    if (watchdog_restart_o === 1'b1)
      kicks <= kicks + 1;
    if (high_z_o === 1'b1 && hz_q !== 1'b1)
      hz_rises <= hz_rises + 1;
    if (charge_adapter_o === 1'b1 && charge_usb_o === 1'b1)
      check(32'h1, 32'h0);
    if (cycles == 90000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    check({31'h0, high_z_o}, 32'h1);
    host_mode_i <= 1'b1;
    repeat (800) @(posedge ref_clk_i);
    check({29'h0, high_z_o, charge_adapter_o, charge_usb_o}, 32'h2);
    hz_before = hz_rises;
    kick_before = kicks;
    xfer(32'h0000_8800, 9'h100, 9'h000);
    repeat (800) @(posedge ref_clk_i);
    check({29'h0, high_z_o, charge_adapter_o, charge_usb_o}, 32'h1);
    check(32'(hz_rises - hz_before), 32'h1);
    check(32'(kicks - kick_before), 32'h1);
    xfer(32'h0000_0100, 9'h1ff, {2'b0, cssc_pkg::ST_CHG_USB, 1'b1, cssc_pkg::FLT_NONE});
    xfer(32'h0000_0007, 9'h100, 9'h000);
    xfer(32'h0000_0100, 9'h1ff, 9'h0ff);
    bus_op(2'h3, 1'b0, 32'h0);
    report_and_stop();
  end
endmodule : charger_serial_status_control_bench
